// File: bench/dsp_ctrl_properties.sv
// assertions on the memory-side pins of dsp_ctrl
// assumes binding into dsp_ctrl; one clock, synchronous reset
`timescale 1ns/1ps
module dsp_ctrl_properties
    import dsp_pkg::*;
#(
    parameter int REFRESH_CYC = REFRESH_INTERVAL_CYC
) (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic [COL_W-1:0] mux_address_pins,
    input wire logic             row_strobe_n,
    input wire logic             lower_lane_col_strobe_n,
    input wire logic             upper_lane_col_strobe_n,
    input wire logic             write_select_n,
    input wire logic             out_enable_n,
    input wire logic             data_pins_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic both_hi, row_q;
    int   pre_q, ref_q;
    assign both_hi = lower_lane_col_strobe_n & upper_lane_col_strobe_n;
    // row-high run and cycles since refresh; reset counts as a long precharge
    always_ff @(posedge clock) begin
        row_q <= row_strobe_n;
        pre_q <= !rst_n ? 255 : (row_strobe_n ? pre_q + 1 : 0);
        ref_q <= (!rst_n || (row_q && !row_strobe_n && !both_hi)) ? 0 : ref_q + 1;
    end
    sequence s_col_fall; $fell(both_hi); endsequence
    sequence s_ref_start; $fell(both_hi) && row_strobe_n; endsequence
    property p_pair; $fell(lower_lane_col_strobe_n) || $fell(upper_lane_col_strobe_n) |-> $past(both_hi); endproperty
    a_pair: assert property (p_pair) else $error("lane strobe fell alone");
    property p_pulse; s_col_fall ##0 !write_select_n |-> ##1 $stable(both_hi); endproperty
    a_pulse: assert property (p_pulse) else $error("write strobe too short");
    property p_addr; $fell(row_strobe_n) || ($fell(both_hi) && !row_strobe_n) |-> $stable(mux_address_pins); endproperty
    a_addr: assert property (p_addr) else $error("address moved at strobe");
    property p_refresh; s_ref_start |-> write_select_n throughout (##[1:8] $fell(row_strobe_n)); endproperty
    a_refresh: assert property (p_refresh) else $error("refresh order broken");
    property p_early; s_col_fall ##0 !write_select_n |-> $past(write_select_n) == 1'b0; endproperty
    a_early: assert property (p_early) else $error("write select late");
    property p_no_clash; data_pins_oe |-> out_enable_n; endproperty
    a_no_clash: assert property (p_no_clash) else $error("bus clash");
    property p_precharge; $fell(row_strobe_n) |-> pre_q >= ROW_PRE_CYC; endproperty
    a_precharge: assert property (p_precharge) else $error("row precharge short");
    property p_ref_due; ref_q <= REFRESH_CYC + 100; endproperty
    a_ref_due: assert property (p_ref_due) else $error("refresh overdue");
endmodule
bind dsp_ctrl dsp_ctrl_properties #(.REFRESH_CYC(REFRESH_CYC)) dsp_ctrl_properties_i (.*);

// File: bench/dsp_ctrl_tb.sv
// self-checking bench: dsp_ctrl driving the behavioural page memory
// assumes dsp_pkg, dsp_ctrl, the model and the checker compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %0t got %h", $time, g); end end
module dsp_ctrl_tb;
    import dsp_pkg::*;
    logic              clock, rst_n, req_valid, req_write, req_ready, rsp_valid, data_pins_oe;
    logic              row_strobe_n, lower_lane_col_strobe_n, upper_lane_col_strobe_n;
    logic              write_select_n, out_enable_n;
    logic [1:0]        req_lanes;
    logic [COL_W-1:0]  mux_address_pins;
    logic [ADDR_W-1:0] req_addr, pool [8];
    logic [DATA_W-1:0] req_wdata, rsp_rdata, data_pins_in, data_pins_out;
    logic [DATA_W-1:0] shadow [bit [ADDR_W-1:0]];
    int                fails, check_count, cyc;
    dsp_ctrl #(.REFRESH_CYC(200)) dsp_ctrl_i (.*);
    dsp_mem_model dsp_mem_model_i (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    // masked write as the memory should apply it; no lanes means both
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [1:0] ln);
        logic [1:0] m;
        m = (ln == 2'h0) ? 2'h3 : ln;
        return {m[1] ? n[15:8] : o[15:8], m[0] ? n[7:0] : o[7:0]};
    endfunction
    task automatic finish_test();
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one request held until taken; a read then waits for its data
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input logic [1:0] ln);
        int n;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        req_lanes <= ln;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        if (n == 400) fails++;
        req_valid <= 1'b0;
        if (!shadow.exists(a)) shadow[a] = '0;
        if (wr) shadow[a] = merge(shadow[a], d, ln);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!wr && rsp_valid !== 1'b1 && n < 400);
        if (n == 400) fails++;
        // lanes whose strobe stays high are not driven, so only enabled bytes count
        if (!wr) `CHK(merge(16'h0, rsp_rdata, ln), merge(16'h0, shadow[a], ln))
    endtask
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        req_lanes = '0;
        pool = '{18'h0, 18'h3ffff, 18'h001ff, 18'h3fe00, 18'h12345, 18'h12200, 18'h2a0aa, 18'h15155};
        void'($urandom(32'hb27d));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        `CHK({row_strobe_n, lower_lane_col_strobe_n, upper_lane_col_strobe_n, out_enable_n, data_pins_oe}, 5'h1e)
        // every lane code at columns 0 and 511 of one row, then read back
        for (int i = 0; i < 6; i++)
            access(i < 4, {9'h1ff, i[0] ? 9'h1ff : 9'h000}, 16'ha5c3 + 16'(i * 16'h1111), 2'(3 - i));
        // random mix of page hits and misses over a small address pool
        for (int i = 0; i < 48; i++)
            access(1'($urandom_range(1)), pool[$urandom_range(7)], 16'($urandom), 2'($urandom_range(3)));
        // idle long enough for several refreshes, data must survive them
        repeat (600) @(posedge clock);
        foreach (pool[i])
            access(1'b0, pool[i], 16'h0, 2'h3);
        finish_test();
    end
endmodule

// File: bench/dsp_mem_model.sv
// behavioural dual-strobe page memory acting on strobe edges
// assumes strobes from dsp_ctrl; undriven lanes show a moving pattern
`timescale 1ns/1ps
module dsp_mem_model
    import dsp_pkg::*;
(
    input  wire logic [COL_W-1:0]  mux_address_pins,
    input  wire logic              row_strobe_n,
    input  wire logic              lower_lane_col_strobe_n,
    input  wire logic              upper_lane_col_strobe_n,
    input  wire logic              write_select_n,
    input  wire logic              out_enable_n,
    input  wire logic [DATA_W-1:0] data_pins_out,
    input  wire logic              data_pins_oe,
    output logic      [DATA_W-1:0] data_pins_in
);
    logic [DATA_W-1:0] mem [bit [ADDR_W-1:0]];
    logic [ADDR_W-1:0] loc;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] junk = 16'h5a5a;
    logic              refr = 1'b1;
    logic              lo_ok = 1'b0;
    logic              hi_ok = 1'b0;
    wire both_hi = lower_lane_col_strobe_n & upper_lane_col_strobe_n;
    wire rd_on = !row_strobe_n && !refr && write_select_n && !out_enable_n;
    wire lo_on = rd_on && !lower_lane_col_strobe_n;
    wire hi_on = rd_on && !upper_lane_col_strobe_n;
    // odd period so stale lane data never lines up with the clock
    always #7 junk = ~junk;
    // strobe already low at row fall means refresh: address ignored
    always @(negedge row_strobe_n) begin
        refr = !both_hi;
        loc[ADDR_W-1:COL_W] = mux_address_pins;
    end
    // first falling column strobe freezes column and write data
    always @(negedge both_hi) begin
        if (!row_strobe_n && !refr) begin
            loc[COL_W-1:0] = mux_address_pins;
            rd = mem.exists(loc) ? mem[loc] : '0;
            if (!write_select_n) begin
                if (!lower_lane_col_strobe_n) rd[7:0] = data_pins_in[7:0];
                if (!upper_lane_col_strobe_n) rd[15:8] = data_pins_in[15:8];
                mem[loc] = rd;
            end
        end
    end
    // lanes turn valid only one column access time after enable
    always @(lo_on) lo_ok <= #(T_COL_ACCESS_NS) lo_on;
    always @(hi_on) hi_ok <= #(T_COL_ACCESS_NS) hi_on;
    assign data_pins_in = data_pins_oe ? data_pins_out :
        {(hi_on && hi_ok) ? rd[15:8] : junk[15:8], (lo_on && lo_ok) ? rd[7:0] : junk[7:0]};
endmodule

// File: core/dsp_ctrl.sv
// host-side controller for a dual-strobe page-mode dynamic memory
// assumes the memory sits outside on plain pins; requests held until accepted
`timescale 1ns/1ps
module dsp_ctrl #(
    parameter int REFRESH_CYC = dsp_pkg::REFRESH_INTERVAL_CYC
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic [dsp_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [dsp_pkg::DATA_W-1:0] req_wdata,
    input  wire logic [1:0]                 req_lanes,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic      [dsp_pkg::DATA_W-1:0] rsp_rdata,
    output logic      [dsp_pkg::COL_W-1:0]  mux_address_pins,
    output logic                            row_strobe_n,
    output logic                            lower_lane_col_strobe_n,
    output logic                            upper_lane_col_strobe_n,
    output logic                            write_select_n,
    output logic                            out_enable_n,
    input  wire logic [dsp_pkg::DATA_W-1:0] data_pins_in,
    output logic      [dsp_pkg::DATA_W-1:0] data_pins_out,
    output logic                            data_pins_oe
);
    import dsp_pkg::*;

    typedef struct packed {
        dsp_state_t             st;
        logic [CNT_W-1:0]       cnt;
        logic [CNT_W-1:0]       ref_cnt;
        logic                   ref_due;
        logic                   open_valid;
        logic [ROW_W-1:0]       open_row;
        logic                   wr;
        logic [COL_W-1:0]       col;
        logic [DATA_W-1:0]      wdata;
        logic [1:0]             lanes;
        logic                   ready;
        logic                   rvalid;
        logic [DATA_W-1:0]      rdata;
        logic [COL_W-1:0]       addr;
        logic                   ras_n;
        logic                   lo_strobe_n;
        logic                   hi_strobe_n;
        logic                   we_n;
        logic                   oe_n;
        logic [DATA_W-1:0]      dout;
        logic                   doe;
    } dsp_regs_t;

    dsp_regs_t s_q;
    dsp_regs_t s_d;

    logic [ROW_W-1:0] req_row;
    logic [COL_W-1:0] req_col;
    assign req_row = req_addr[ADDR_W-1:COL_W];
    assign req_col = req_addr[COL_W-1:0];

    // next-state logic; strobes are held as registers so pins never glitch
    always_comb begin
        s_d        = s_q;
        s_d.ready  = 1'b0;
        s_d.rvalid = 1'b0;
        // refresh timer runs always; a due refresh beats new requests
        if (s_q.ref_cnt == CNT_W'(0)) begin
            s_d.ref_cnt = CNT_W'(REFRESH_CYC - 1);
            s_d.ref_due = 1'b1;
        end else begin
            s_d.ref_cnt = s_q.ref_cnt - CNT_W'(1);
        end
        if (s_q.cnt != CNT_W'(0)) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
        end
        case (s_q.st)
            DSP_IDLE: begin
                if (s_q.ref_due) begin
                    if (s_q.open_valid) begin
                        // close the page before refreshing
                        s_d.ras_n      = 1'b1;
                        s_d.open_valid = 1'b0;
                        s_d.cnt        = CNT_W'(ROW_PRE_CYC);
                        s_d.st         = DSP_PRECHARGE;
                    end else if (s_q.cnt == CNT_W'(0)) begin
                        s_d.lo_strobe_n = 1'b0;
                        s_d.hi_strobe_n = 1'b0;
                        s_d.cnt    = CNT_W'(PULSE_CYC);
                        s_d.st     = DSP_REF_COL;
                    end
                end else if (req_valid && s_q.cnt == CNT_W'(0)) begin
                    s_d.ready = 1'b1;
                    s_d.wr    = req_write;
                    s_d.col   = req_col;
                    s_d.wdata = req_wdata;
                    s_d.lanes = (req_lanes == 2'h0) ? 2'h3 : req_lanes;
                    if (s_q.open_valid && s_q.open_row == req_row) begin
                        // page hit: row stays open, column goes out now
                        s_d.addr = req_col;
                        s_d.st   = DSP_COL;
                        s_d.cnt  = CNT_W'(1);
                    end else if (s_q.open_valid) begin
                        // page miss: close row, the request is retaken later
                        s_d.ready      = 1'b0;
                        s_d.ras_n      = 1'b1;
                        s_d.open_valid = 1'b0;
                        s_d.cnt        = CNT_W'(ROW_PRE_CYC);
                        s_d.st         = DSP_PRECHARGE;
                    end else begin
                        s_d.addr     = req_row;
                        s_d.open_row = req_row;
                        s_d.st       = DSP_ROW;
                    end
                end
            end
            DSP_ROW: begin
                s_d.ras_n      = 1'b0;
                s_d.open_valid = 1'b1;
                s_d.cnt        = CNT_W'(ROW_HOLD_CYC);
                s_d.st         = DSP_ROW_HOLD;
            end
            DSP_ROW_HOLD: begin
                if (s_q.cnt == CNT_W'(0)) begin
                    s_d.addr = s_q.col;
                    s_d.cnt  = CNT_W'(1);
                    s_d.st   = DSP_COL;
                end
            end
            DSP_COL: begin
                // write select and data lead the strobes by a cycle, so every
                // write is an early write and the memory never races us on it
                s_d.we_n = ~s_q.wr;
                s_d.dout = s_q.wdata;
                s_d.doe  = s_q.wr;
                // the enabled lanes' strobes fall together, so the first edge is shared
                if (s_q.cnt == CNT_W'(0)) begin
                    s_d.lo_strobe_n = ~s_q.lanes[0];
                    s_d.hi_strobe_n = ~s_q.lanes[1];
                    s_d.oe_n        = s_q.wr;
                    s_d.cnt         = CNT_W'(s_q.wr ? PULSE_CYC : ROW_ACC_CYC);
                    s_d.st          = DSP_ACCESS;
                end
            end
            DSP_ACCESS: begin
                // read waits the row access figure, covering column access too
                if (s_q.cnt == CNT_W'(0)) begin
                    if (!s_q.wr) begin
                        s_d.rvalid = 1'b1;
                        s_d.rdata  = data_pins_in;
                    end
                    s_d.lo_strobe_n = 1'b1;
                    s_d.hi_strobe_n = 1'b1;
                    s_d.we_n   = 1'b1;
                    s_d.oe_n   = 1'b1;
                    s_d.doe    = 1'b0;
                    s_d.cnt    = CNT_W'(COL_PRE_CYC);
                    s_d.st     = DSP_COL_PRE;
                end
            end
            DSP_COL_PRE: begin
                if (s_q.cnt == CNT_W'(0)) begin
                    s_d.st = DSP_IDLE;
                end
            end
            DSP_PRECHARGE: begin
                if (s_q.cnt == CNT_W'(0)) begin
                    s_d.st = DSP_IDLE;
                end
            end
            DSP_REF_COL: begin
                if (s_q.cnt == CNT_W'(0)) begin
                    s_d.ras_n = 1'b0;
                    s_d.cnt   = CNT_W'(ROW_ACC_CYC);
                    s_d.st    = DSP_REF_ROW;
                end
            end
            DSP_REF_ROW: begin
                if (s_q.cnt == CNT_W'(0)) begin
                    s_d.ras_n   = 1'b1;
                    s_d.lo_strobe_n = 1'b1;
                    s_d.hi_strobe_n = 1'b1;
                    s_d.ref_due = 1'b0;
                    s_d.cnt     = CNT_W'(ROW_PRE_CYC);
                    s_d.st      = DSP_PRECHARGE;
                end
            end
            default: begin
                s_d.st = DSP_IDLE;
            end
        endcase
        // a refresh tick landing as the flag clears is kept
        if (s_q.ref_cnt == CNT_W'(0)) begin
            s_d.ref_due = 1'b1;
        end
    end

    // single state register; reset parks all strobes inactive
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.st      <= DSP_IDLE;
            s_q.ref_cnt <= CNT_W'(REFRESH_CYC - 1);
            s_q.ras_n   <= 1'b1;
            s_q.lo_strobe_n <= 1'b1;
            s_q.hi_strobe_n <= 1'b1;
            s_q.we_n    <= 1'b1;
            s_q.oe_n    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready               = s_q.ready;
    assign rsp_valid               = s_q.rvalid;
    assign rsp_rdata               = s_q.rdata;
    assign mux_address_pins        = s_q.addr;
    assign row_strobe_n            = s_q.ras_n;
    assign lower_lane_col_strobe_n = s_q.lo_strobe_n;
    assign upper_lane_col_strobe_n = s_q.hi_strobe_n;
    assign write_select_n          = s_q.we_n;
    assign out_enable_n            = s_q.oe_n;
    assign data_pins_out           = s_q.dout;
    assign data_pins_oe            = s_q.doe;
endmodule

// File: include/dsp_pkg.sv
// constants for the dual-strobe page memory controller
// assumes a 100 MHz clock and a strobe-driven, clockless memory outside
// What this block does
// - both strobes high for precharge before new column
// - overlap strobes when holding one column address
// - hold asserted strobes for minimum pulse width
// - nine row then nine column bits, 16-bit word
// - address stable before row and column strobes fall
// - write select high reads, low writes
// - output enable high before driving delayed write data
// - refresh all 512 rows every 8 ms
// - column-first refresh uses internal row counter
package dsp_pkg;
    localparam int CLK_NS       = 10;
    localparam int ROW_W        = 9;
    localparam int COL_W        = 9;
    localparam int ADDR_W       = ROW_W + COL_W;
    localparam int DATA_W       = 16;
    localparam int LANE_W       = 8;
    localparam int ROWS         = 512;
    // timing figures in ns, refresh in ms; counts rounded up (least) or down (longest)
    localparam int T_ROW_HOLD_NS   = 10;
    localparam int T_ROW_ACCESS_NS = 80;
    localparam int T_COL_ACCESS_NS = 20;
    localparam int T_PULSE_NS      = 20;
    localparam int T_COL_PRE_NS    = 10;
    localparam int T_ROW_PRE_NS    = 60;
    localparam int T_REFRESH_MS    = 8;
    localparam int ROW_HOLD_CYC   = (T_ROW_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_ACC_CYC    = (T_ROW_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int COL_ACC_CYC    = (T_COL_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC      = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int COL_PRE_CYC    = (T_COL_PRE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_PRE_CYC    = (T_ROW_PRE_NS + CLK_NS - 1) / CLK_NS;
    // longest refresh spacing per row, rounded down
    localparam int REFRESH_INTERVAL_CYC = (T_REFRESH_MS * 1000000 / CLK_NS) / ROWS;
    localparam int CNT_W = 16;
    typedef enum logic [3:0] {
        DSP_IDLE, DSP_ROW, DSP_ROW_HOLD, DSP_COL, DSP_ACCESS, DSP_COL_PRE,
        DSP_PRECHARGE, DSP_REF_COL, DSP_REF_ROW
    } dsp_state_t;
endpackage
